// [include/canopen_consts.vh]
// Purpose: Shared constants of the CANopen SDO read server.
// Assumes: Byte offsets on the register bus, 8-bit node numbers.
// Notes:   Node value 8'hff stands for the setting -1.
`ifndef CANOPEN_CONSTS_VH
`define CANOPEN_CONSTS_VH
// Register byte offsets
`define REG_PORT_SEL     6'h00
`define REG_NODE_NUM     6'h04
`define REG_BITRATE      6'h08
`define REG_SYSBUS_ID    6'h0c
`define REG_FAULT_REACT  6'h10
`define REG_STATUS       6'h14
`define REG_SDO_COUNT    6'h18
// Port selection codes and reset value
`define PORT_BUILTIN     2'h1
`define PORT_EXPANSION   2'h2
// Node number limits and reset value
`define NODE_OFF         8'hff
`define NODE_MAX         8'h7f
// Bit rate codes
`define BITRATE_MIN      4'h1
`define BITRATE_MAX      4'h8
`define BITRATE_RST      4'h6
// Fault reaction codes
`define FR_KEEP          3'h0
`define FR_FAULT         3'h1
`define FR_SWITCH_OFF    3'h2
`define FR_QSTOP_DIS     3'h3
`define FR_RAMP_FAULT    3'h4
`define FR_QSTOP_FAULT   3'h5
`define FR_RST           3'h1
// Status field positions
`define ST_ACTIVE        0
`define ST_EXP_FITTED    1
`define ST_SYSBUS_EN     2
`define ST_SDO_BUSY      3
// SDO framing
`define SDO_RX_BASE      11'h600
`define SDO_TX_BASE      11'h580
`define SDO_FRAME_LEN    4'h8
`define CS_UPLOAD_REQ    8'h40
`define CS_ABORT         8'h80
`define CS_UP_1          8'h4f
`define CS_UP_2          8'h4b
`define CS_UP_3          8'h47
`define CS_UP_4          8'h43
`define ABORT_UNSUPP     32'h06010000
// Object dictionary
`define OBJ_ABORT_OPT    16'h6007
`define IDX_MFR_LO       16'h2000
`define IDX_MFR_HI       16'h5fff
`define IDX_COMM_NIB     4'h1
`define IDX_PROF_NIB     4'h6
`endif

// [verilog/sdo_response_builder.v]
// Purpose: Packs one eight-byte SDO response or abort frame.
// Assumes: Frame byte 0 sits in bits 7:0.
// Notes:   Purely combinational; the caller registers the result.
`timescale 1ns/1ns
`default_nettype none
`include "canopen_consts.vh"
module sdo_response_builder (
	input  wire        abort,
	input  wire [2:0]  len,
	input  wire [15:0] index,
	input  wire [7:0]  sub,
	input  wire [31:0] value,
	input  wire [31:0] abort_code,
	output reg  [63:0] frame
);
	// Command specifier from the count of valid bytes
	function [7:0] cs_for_len;
		input [2:0] n;
		begin
			case (n)
				3'h1: cs_for_len = `CS_UP_1;
				3'h2: cs_for_len = `CS_UP_2;
				3'h3: cs_for_len = `CS_UP_3;
				default: cs_for_len = `CS_UP_4;
			endcase
		end
	endfunction

	// Index echoed low byte first, payload first byte in byte 4
	always @* begin
		if (abort) begin
			frame = {abort_code, sub, index[15:8], index[7:0], `CS_ABORT};
		end else begin
			frame = {value, sub, index[15:8], index[7:0], cs_for_len(len)};
		end
	end
endmodule // sdo_response_builder
`default_nettype wire

// [verilog/bus_fault_reaction.v]
// Purpose: Turns a bus failure into drive state machine commands.
// Assumes: Events and drive status come from logic on the same clock.
// Notes:   Command outputs are one-cycle pulses from flip-flops.
`timescale 1ns/1ns
`default_nettype none
`include "canopen_consts.vh"
module bus_fault_reaction (
	input  wire       core_clk,
	input  wire       srst,
	input  wire       bus_fail,
	input  wire [2:0] reaction,
	input  wire       remote_ctrl,
	input  wire       drive_stopped,
	output reg        cmd_fault,
	output reg        cmd_disable_voltage,
	output reg        cmd_quick_stop,
	output reg        cmd_disable_op,
	output reg        to_switch_on_disabled,
	output reg        waiting_stop
);
	// Stopping reactions only apply under remote control
	wire staged = remote_ctrl;

	// Issue commands, then wait for standstill where a fault follows
	always @(posedge core_clk) begin
		if (srst) begin
			cmd_fault <= 1'b0;
			cmd_disable_voltage <= 1'b0;
			cmd_quick_stop <= 1'b0;
			cmd_disable_op <= 1'b0;
			to_switch_on_disabled <= 1'b0;
			waiting_stop <= 1'b0;
		end else begin
			cmd_fault <= 1'b0;
			cmd_disable_voltage <= 1'b0;
			cmd_quick_stop <= 1'b0;
			cmd_disable_op <= 1'b0;
			to_switch_on_disabled <= 1'b0;
			if (waiting_stop && drive_stopped) begin
				// Stopped: now enter the fault state
				cmd_fault <= 1'b1;
				waiting_stop <= 1'b0;
			end else if (bus_fail) begin
				case (reaction)
					`FR_FAULT: cmd_fault <= 1'b1;
					`FR_SWITCH_OFF: begin
						cmd_disable_voltage <= staged;
						to_switch_on_disabled <= staged;
					end
					`FR_QSTOP_DIS: begin
						cmd_quick_stop <= staged;
						to_switch_on_disabled <= staged;
					end
					`FR_RAMP_FAULT: begin
						cmd_disable_op <= staged;
						waiting_stop <= staged;
					end
					`FR_QSTOP_FAULT: begin
						cmd_quick_stop <= staged;
						waiting_stop <= staged;
					end
					default: ; // Keep operating point
				endcase
			end
		end
	end
endmodule // bus_fault_reaction
`default_nettype wire

// [verilog/canopen_sdo_server.v]
// Purpose: CANopen node settings, bus failure handling and SDO upload server.
// Assumes: CAN controller frames and dictionary answers on core_clk.
// Notes:   Registers on Avalon-MM; one answer cycle after each request.
//
// Overview of operation
// - Port change only with both IDs at -1
// - Expansion port needs fitted module; built-in default
// - Port reads 1 until rewritten to 2
// - Expansion port: own rate, system bus locked (code drives the chosen port with the one CANopen bit rate register)
// - Six bus events count as bus failure
// - Reaction 0 keeps point, 1 faults
// - Reactions 2,3 stop to switch-on-disabled
// - Reactions 4,5 stop, then fault
// - Reactions 2 to 5 depend on control location
// - Reaction shared with abort option object
// - Objects addressed by index and sub-index
// - Service identifier is base plus node
// - Index ranges classify objects
// - Up to four bytes expedited, larger segmented (code aborts larger objects instead)
// - Exactly one server SDO channel
// - Eight-byte SDO frame layout
// - Request 0x600, response 0x580 plus node
// - Response echoes index, data from byte 4
// - Specifier encodes count of valid bytes
// - Node -1 off, 0 refused, max 127
// - Node change restarts communication only
// - Bit rate codes 1 to 8, default 6
// - Failed access answered by abort frame
//
// Implementation choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
`include "canopen_consts.vh"
module canopen_sdo_server (
	input  wire        core_clk,
	input  wire        srst,
	// Avalon-MM slave
	input  wire [5:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output reg  [31:0] avs_readdata,
	output reg         avs_waitrequest,
	// Straps and drive status
	input  wire        expansion_fitted,
	input  wire        remote_ctrl,
	input  wire        drive_stopped,
	// Bus failure events, one-cycle pulses
	input  wire        bus_off,
	input  wire        guard_lost,
	input  wire        heartbeat_lost,
	input  wire        sync_err,
	input  wire        rpdo_len_err,
	input  wire        nmt_left_op,
	// Abort option object written from the dictionary side
	input  wire        abort_opt_wr,
	input  wire [2:0]  abort_opt_data,
	// Received frame on the request channel
	input  wire        rx_valid,
	input  wire [10:0] rx_id,
	input  wire [3:0]  rx_dlc,
	input  wire [63:0] rx_data,
	// Response channel frame
	output reg         tx_valid,
	input  wire        tx_ready,
	output reg  [10:0] tx_id,
	output reg  [63:0] tx_data,
	// Dictionary lookup
	output reg         od_req,
	output reg  [15:0] od_index,
	output reg  [7:0]  od_sub,
	output reg  [1:0]  od_class,
	input  wire        od_ack,
	input  wire [31:0] od_value,
	input  wire [2:0]  od_len,
	input  wire        od_err,
	input  wire [31:0] od_abort_code,
	// Link and drive control
	output reg  [1:0]  can_port,
	output reg  [3:0]  can_bitrate,
	output reg         sysbus_enable,
	output reg         canopen_restart,
	output wire        cmd_fault,
	output wire        cmd_disable_voltage,
	output wire        cmd_quick_stop,
	output wire        cmd_disable_op,
	output wire        to_switch_on_disabled
);
	// Server states, one-hot
	localparam [2:0] S_IDLE   = 3'b001;
	localparam [2:0] S_LOOKUP = 3'b010;
	localparam [2:0] S_SEND   = 3'b100;

	// Setting registers and counters
	reg  [1:0]  port_sel;       // CAN port selection
	reg  [7:0]  node_num;       // CANopen node number
	reg  [3:0]  bitrate;        // Bit rate code
	reg  [7:0]  sysbus_id;      // System bus node identifier
	reg  [2:0]  fault_react;    // Bus failure reaction
	reg  [7:0]  restart_cnt;    // Count of communication restarts
	reg  [15:0] read_cnt;       // Served uploads
	reg  [15:0] abort_cnt;      // Abort frames sent
	// Strap synchroniser
	reg         fit_meta;       // First stage, read only by fit_sync
	reg         fit_sync;       // Expansion module present
	// Server state
	reg  [2:0]  state;          // One-hot server state
	reg  [15:0] req_index;      // Latched request index
	reg  [7:0]  req_sub;        // Latched request sub-index
	reg         resp_abort;     // Response is an abort
	reg  [2:0]  resp_len;       // Valid byte count
	reg  [31:0] resp_value;     // Response payload
	reg  [31:0] resp_code;      // Abort code
	wire [63:0] resp_frame;     // Packed response
	wire        waiting_stop;   // Fault module awaiting standstill

	// Service identifier from a base and the node number
	function [10:0] cob_id;
		input [10:0] base;
		input [7:0]  node;
		begin
			cob_id = base + {4'h0, node[6:0]};
		end
	endfunction

	// Object class: 1 comm, 2 manufacturer, 3 profile, 0 other
	function [1:0] obj_class;
		input [15:0] idx;
		begin
			if (idx[15:12] == `IDX_COMM_NIB) begin
				obj_class = 2'h1;
			end else if (idx >= `IDX_MFR_LO && idx <= `IDX_MFR_HI) begin
				obj_class = 2'h2;
			end else if (idx[15:12] == `IDX_PROF_NIB) begin
				obj_class = 2'h3;
			end else begin
				obj_class = 2'h0;
			end
		end
	endfunction

	// Node value accepted: off, or 1 to 127
	function node_ok;
		input [7:0] v;
		begin
			node_ok = (v == `NODE_OFF) || (v != 8'h00 && v <= `NODE_MAX);
		end
	endfunction

	wire node_active = (node_num != `NODE_OFF);
	wire both_off    = (node_num == `NODE_OFF) && (sysbus_id == `NODE_OFF);
	wire exp_sel     = (port_sel == `PORT_EXPANSION);
	wire bus_fail    = bus_off | guard_lost | heartbeat_lost
	                 | sync_err | rpdo_len_err | nmt_left_op;
	wire acc         = !avs_waitrequest;                      // Access completes this edge
	wire do_wr       = avs_write && acc && avs_byteenable[0];
	wire [7:0] wr8   = avs_writedata[7:0];
	wire sdo_match   = rx_valid && node_active
	                 && rx_id == cob_id(`SDO_RX_BASE, node_num)
	                 && rx_dlc == `SDO_FRAME_LEN;

	// Strap from a pin passes two flops before use
	always @(posedge core_clk) begin
		if (srst) begin
			fit_meta <= 1'b0;
			fit_sync <= 1'b0;
		end else begin
			fit_meta <= expansion_fitted;
			fit_sync <= fit_meta;
		end
	end

	// Waitrequest drops for one cycle after each request is seen
	always @(posedge core_clk) begin
		if (srst) begin
			avs_waitrequest <= 1'b1;
		end else if ((avs_read || avs_write) && avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	// Read data captured while waitrequest is high, held through the answer
	always @(posedge core_clk) begin
		if (srst) begin
			avs_readdata <= 32'h00000000;
		end else if (avs_read && avs_waitrequest) begin
			if (avs_address == `REG_PORT_SEL) begin
				avs_readdata <= {30'h0, port_sel};
			end else if (avs_address == `REG_NODE_NUM) begin
				avs_readdata <= {24'h0, node_num};
			end else if (avs_address == `REG_BITRATE) begin
				avs_readdata <= {28'h0, bitrate};
			end else if (avs_address == `REG_SYSBUS_ID) begin
				avs_readdata <= {24'h0, sysbus_id};
			end else if (avs_address == `REG_FAULT_REACT) begin
				avs_readdata <= {29'h0, fault_react};
			end else if (avs_address == `REG_STATUS) begin
				avs_readdata <= {16'h0, restart_cnt, 3'h0, waiting_stop,
				                 state != S_IDLE, sysbus_enable, fit_sync, node_active};
			end else if (avs_address == `REG_SDO_COUNT) begin
				avs_readdata <= {abort_cnt, read_cnt};
			end else begin
				// Unmapped offsets read as zero
				avs_readdata <= 32'h00000000;
			end
		end
	end

	// Node settings; illegal values are dropped without a change
	always @(posedge core_clk) begin
		if (srst) begin
			port_sel <= `PORT_BUILTIN;
			node_num <= `NODE_OFF;
			bitrate <= `BITRATE_RST;
			sysbus_id <= `NODE_OFF;
		end else if (do_wr) begin
			if (avs_address == `REG_PORT_SEL) begin
				// With both IDs at -1: built-in allowed; expansion only with module fitted
				if (both_off && (wr8[1:0] == `PORT_BUILTIN
				    || (wr8[1:0] == `PORT_EXPANSION && fit_sync)) && wr8[7:2] == 6'h0) begin
					port_sel <= wr8[1:0];
				end
			end else if (avs_address == `REG_NODE_NUM) begin
				if (node_ok(wr8)) begin
					node_num <= wr8;
				end
			end else if (avs_address == `REG_BITRATE) begin
				if (wr8 >= {4'h0, `BITRATE_MIN} && wr8 <= {4'h0, `BITRATE_MAX}) begin
					bitrate <= wr8[3:0];
				end
			end else if (avs_address == `REG_SYSBUS_ID) begin
				// Locked at -1 while the expansion port carries the link
				if (!exp_sel && node_ok(wr8)) begin
					sysbus_id <= wr8;
				end
			end
		end
	end

	// Reaction has one store reached from the bus and from the object
	always @(posedge core_clk) begin
		if (srst) begin
			fault_react <= `FR_RST;
		end else if (abort_opt_wr && abort_opt_data <= `FR_QSTOP_FAULT) begin
			fault_react <= abort_opt_data;
		end else if (do_wr && avs_address == `REG_FAULT_REACT
		             && wr8 <= {5'h0, `FR_QSTOP_FAULT}) begin
			fault_react <= wr8[2:0];
		end
	end

	// Link control outputs and restart pulse on node or rate change
	always @(posedge core_clk) begin
		if (srst) begin
			can_port <= `PORT_BUILTIN;
			can_bitrate <= `BITRATE_RST;
			sysbus_enable <= 1'b0;
			canopen_restart <= 1'b0;
			restart_cnt <= 8'h00;
		end else begin
			can_port <= port_sel;
			// The CANopen rate drives the chosen port
			can_bitrate <= bitrate;
			sysbus_enable <= !exp_sel && sysbus_id != `NODE_OFF;
			canopen_restart <= 1'b0;
			if (do_wr && ((avs_address == `REG_NODE_NUM && node_ok(wr8) && wr8 != node_num)
			    || (avs_address == `REG_BITRATE && wr8 >= {4'h0, `BITRATE_MIN}
			        && wr8 <= {4'h0, `BITRATE_MAX} && wr8[3:0] != bitrate))) begin
				// Only communication restarts, the drive keeps running
				canopen_restart <= 1'b1;
				restart_cnt <= restart_cnt + 8'h01;
			end
		end
	end

	// Single server channel: one request in flight, others dropped
	always @(posedge core_clk) begin
		if (srst) begin
			state <= S_IDLE;
			req_index <= 16'h0000;
			req_sub <= 8'h00;
			resp_abort <= 1'b0;
			resp_len <= 3'h0;
			resp_value <= 32'h00000000;
			resp_code <= 32'h00000000;
			od_req <= 1'b0;
			od_index <= 16'h0000;
			od_sub <= 8'h00;
			od_class <= 2'h0;
			tx_valid <= 1'b0;
			tx_id <= 11'h000;
			tx_data <= 64'h0;
			read_cnt <= 16'h0000;
			abort_cnt <= 16'h0000;
		end else if (canopen_restart || !node_active) begin
			// Restart or deactivation discards any open transfer
			state <= S_IDLE;
			od_req <= 1'b0;
			tx_valid <= 1'b0;
		end else begin
			case (state)
				S_IDLE: begin
					if (sdo_match) begin
						// Index low byte first, sub-index in byte 3
						req_index <= {rx_data[23:16], rx_data[15:8]};
						req_sub <= rx_data[31:24];
						if (rx_data[7:0] != `CS_UPLOAD_REQ) begin
							// Downloads and segments are not served here
							resp_abort <= 1'b1;
							resp_code <= `ABORT_UNSUPP;
							state <= S_SEND;
						end else if ({rx_data[23:16], rx_data[15:8]} == `OBJ_ABORT_OPT
						             && rx_data[31:24] == 8'h00) begin
							// Reaction served locally from its own store
							resp_abort <= 1'b0;
							resp_len <= 3'h2;
							resp_value <= {29'h0, fault_react};
							state <= S_SEND;
						end else begin
							od_req <= 1'b1;
							od_index <= {rx_data[23:16], rx_data[15:8]};
							od_sub <= rx_data[31:24];
							od_class <= obj_class({rx_data[23:16], rx_data[15:8]});
							state <= S_LOOKUP;
						end
					end
				end
				S_LOOKUP: begin
					if (od_ack) begin
						od_req <= 1'b0;
						if (od_err) begin
							resp_abort <= 1'b1;
							resp_code <= od_abort_code;
						end else if (od_len == 3'h0 || od_len > 3'h4) begin
							// Larger objects need segmented transfer
							resp_abort <= 1'b1;
							resp_code <= `ABORT_UNSUPP;
						end else begin
							resp_abort <= 1'b0;
							resp_len <= od_len;
							resp_value <= od_value;
						end
						state <= S_SEND;
					end
				end
				S_SEND: begin
					if (!tx_valid) begin
						tx_valid <= 1'b1;
						tx_id <= cob_id(`SDO_TX_BASE, node_num);
						tx_data <= resp_frame;
					end else if (tx_ready) begin
						tx_valid <= 1'b0;
						state <= S_IDLE;
						if (resp_abort) begin
							abort_cnt <= abort_cnt + 16'h0001;
						end else begin
							read_cnt <= read_cnt + 16'h0001;
						end
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	// Response framing
	sdo_response_builder u_builder (
		.abort      (resp_abort),
		.len        (resp_len),
		.index      (req_index),
		.sub        (req_sub),
		.value      (resp_value),
		.abort_code (resp_code),
		.frame      (resp_frame)
	);

	// Bus failure reaction
	bus_fault_reaction u_fault (
		.core_clk              (core_clk),
		.srst                  (srst),
		.bus_fail              (bus_fail),
		.reaction              (fault_react),
		.remote_ctrl           (remote_ctrl),
		.drive_stopped         (drive_stopped),
		.cmd_fault             (cmd_fault),
		.cmd_disable_voltage   (cmd_disable_voltage),
		.cmd_quick_stop        (cmd_quick_stop),
		.cmd_disable_op        (cmd_disable_op),
		.to_switch_on_disabled (to_switch_on_disabled),
		.waiting_stop          (waiting_stop)
	);
endmodule // canopen_sdo_server
`default_nettype wire

// [test/canopen_sdo_server_assertions.sv]
// Purpose: Port-level checks of the SDO read server.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Bound to every instance of the server.
`timescale 1ns/1ns
`default_nettype none
module canopen_sdo_server_checker (
	input wire logic        core_clk,
	input wire logic        srst,
	input wire logic [5:0]  avs_address,
	input wire logic        avs_write,
	input wire logic        avs_waitrequest,
	input wire logic        remote_ctrl,
	input wire logic        bus_off,
	input wire logic        guard_lost,
	input wire logic        heartbeat_lost,
	input wire logic        sync_err,
	input wire logic        rpdo_len_err,
	input wire logic        nmt_left_op,
	input wire logic        tx_valid,
	input wire logic        tx_ready,
	input wire logic [10:0] tx_id,
	input wire logic [63:0] tx_data,
	input wire logic        od_req,
	input wire logic [15:0] od_index,
	input wire logic [7:0]  od_sub,
	input wire logic [1:0]  od_class,
	input wire logic        od_ack,
	input wire logic [31:0] od_value,
	input wire logic [2:0]  od_len,
	input wire logic        od_err,
	input wire logic [31:0] od_abort_code,
	input wire logic [1:0]  can_port,
	input wire logic        sysbus_enable,
	input wire logic        canopen_restart,
	input wire logic        cmd_fault,
	input wire logic        cmd_disable_voltage,
	input wire logic        cmd_quick_stop,
	input wire logic        cmd_disable_op,
	input wire logic        to_switch_on_disabled
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	// Any of the six failure sources
	wire       any_fail = bus_off | guard_lost | heartbeat_lost | sync_err | rpdo_len_err | nmt_left_op;
	// Dictionary answer usable as an expedited upload
	sequence s_ack_ok;
		od_req && od_ack && !od_err && od_len != 3'h0 && od_len < 3'h5;
	endsequence
	// Dictionary answer that reports a failure
	sequence s_ack_err;
		od_req && od_ack && od_err;
	endsequence
	property p_upload;
		s_ack_ok |-> ##2 tx_valid && tx_data[39:8] == $past({od_value[7:0], od_sub, od_index}, 2)
			&& tx_data[7:0] == 8'h53 - {$past(od_len, 2), 2'b00};
	endproperty
	a_upload: assert property (p_upload) else $error("upload response wrong");
	property p_abort;
		s_ack_err |-> ##2 tx_valid && tx_data[7:0] == 8'h80 && tx_data[63:32] == $past(od_abort_code, 2);
	endproperty
	a_abort: assert property (p_abort) else $error("abort frame wrong");
	property p_txid;
		tx_valid |-> tx_id[10:7] == 4'hb;
	endproperty
	a_txid: assert property (p_txid) else $error("response identifier outside range");
	property p_hold;
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_id);
	endproperty
	a_hold: assert property (p_hold) else $error("response frame changed while waiting");
	property p_class;
		od_req |-> od_class == ((od_index[15:12] == 4'h1) ? 2'h1 : (od_index >= 16'h2000 && od_index <= 16'h5fff)
			? 2'h2 : (od_index[15:12] == 4'h6) ? 2'h3 : 2'h0);
	endproperty
	a_class: assert property (p_class) else $error("object class wrong");
	property p_cause;
		cmd_disable_voltage || cmd_quick_stop || cmd_disable_op || to_switch_on_disabled |-> $past(any_fail && remote_ctrl);
	endproperty
	a_cause: assert property (p_cause) else $error("stop command without remote failure");
	property p_sod;
		to_switch_on_disabled |-> (cmd_disable_voltage ^ cmd_quick_stop) && !cmd_fault;
	endproperty
	a_sod: assert property (p_sod) else $error("switch-on-disabled without its command");
	property p_port;
		can_port == 2'h2 |-> !sysbus_enable;
	endproperty
	a_port: assert property (p_port) else $error("system bus on with expansion port");
	property p_restart;
		canopen_restart |-> $past(avs_write && !avs_waitrequest && (avs_address == 6'h04 || avs_address == 6'h08));
	endproperty
	a_restart: assert property (p_restart) else $error("restart without node or rate write");
endmodule // canopen_sdo_server_checker
bind canopen_sdo_server canopen_sdo_server_checker u_chk (.*);
`default_nettype wire

// [test/sdo_client_model.sv]
// Purpose: Behavioural SDO client on the far side of the server.
// Assumes: One request outstanding at a time.
// Notes:   Idle data lines show the inverse of the last frame.
`timescale 1ns/1ns
`default_nettype none
module sdo_client_model (
	input  wire logic        core_clk,
	input  wire logic [3:0]  stall,
	output var  logic        rx_valid,
	output var  logic [10:0] rx_id,
	output var  logic [3:0]  rx_dlc,
	output var  logic [63:0] rx_data,
	input  wire logic        tx_valid,
	input  wire logic [10:0] tx_id,
	input  wire logic [63:0] tx_data,
	output var  logic        tx_ready
);
	logic [63:0] rsp = 64'h0;    // Last response taken
	logic [10:0] rsp_id = 11'h0; // Its identifier
	logic        got = 1'b0;     // Response taken since last request
	logic [3:0]  cnt = 4'h0;     // Cycles stalled so far
	initial begin
		rx_valid = 1'b0;
		rx_id = 11'h0;
		rx_dlc = 4'h0;
		rx_data = 64'h0;
		tx_ready = 1'b0;
	end
	// One eight-byte upload request with an all-zero data field
	task automatic send(input logic [10:0] id, input logic [7:0] cs, input logic [15:0] idx, input logic [7:0] sub);
		@(posedge core_clk);
		got <= 1'b0;
		rx_valid <= 1'b1;
		rx_id <= id;
		rx_dlc <= 4'h8;
		rx_data <= {32'h0, sub, idx, cs};
		@(posedge core_clk);
		rx_valid <= 1'b0;
		rx_data <= ~rx_data;
	endtask
	// Stalls, then takes the single response to the request
	always @(posedge core_clk) begin
		if (tx_valid && tx_ready) begin
			got <= 1'b1;
			rsp <= tx_data;
			rsp_id <= tx_id;
			tx_ready <= 1'b0;
			cnt <= 4'h0;
		end else if (tx_valid) begin
			cnt <= cnt + 4'h1;
			tx_ready <= (cnt >= stall);
		end
	end
endmodule // sdo_client_model
`default_nettype wire

// [test/canopen_sdo_server_tb.sv]
// Purpose: Self-checking bench of the SDO read server.
// Assumes: The client model and a simple dictionary stand around it.
// Notes:   Settings rows first, then link, upload and fault cases.
`timescale 1ns/1ns
`default_nettype none
module canopen_sdo_server_tb;
	logic        core_clk, avs_waitrequest, tx_valid, tx_ready, od_req, sysbus_enable, canopen_restart, rx_valid;
	logic        srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, expansion_fitted = 1'b0, remote_ctrl = 1'b0;
	logic        drive_stopped = 1'b0, abort_opt_wr = 1'b0, od_ack = 1'b0, od_err = 1'b0;
	logic [5:0]  avs_address = 6'h0, ev = 6'h0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rd, od_value = 32'h44332211, od_abort_code = 32'h06020000;
	logic [2:0]  abort_opt_data = 3'h0, od_len = 3'h1;
	logic [3:0]  stall = 4'h0, rx_dlc, can_bitrate;
	logic [10:0] rx_id, tx_id;
	logic [63:0] rx_data, tx_data;
	logic [15:0] od_index;
	logic [7:0]  od_sub;
	logic [1:0]  od_class, can_port;
	wire  [4:0]  cmds;           // Fault, disable voltage, quick stop, disable op, switch-on-disabled
	int          n_mismatch = 0;
	int          num_checks = 0;
	int          i;
	// Rows: offset, write flag, write data, expected readback
	logic [31:0] rows [11] = '{32'h00000001, 32'h040000ff, 32'h08000006, 32'h0c0000ff, 32'h10000001,
		32'h00010201, 32'h040100ff, 32'h040180ff, 32'h08010906, 32'h08010808, 32'h10010601};
	canopen_sdo_server u_dut (.*, .avs_byteenable(4'hf), .bus_off(ev[0]), .guard_lost(ev[1]), .heartbeat_lost(ev[2]),
		.sync_err(ev[3]), .rpdo_len_err(ev[4]), .nmt_left_op(ev[5]), .cmd_fault(cmds[4]), .cmd_disable_voltage(cmds[3]),
		.cmd_quick_stop(cmds[2]), .cmd_disable_op(cmds[1]), .to_switch_on_disabled(cmds[0]));
	sdo_client_model u_cli (.*);
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	// Dictionary answers each lookup one cycle after it appears
	always @(posedge core_clk) od_ack <= od_req && !od_ack;
	task automatic chk(input logic ok, input string m);
		num_checks++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask
	// One Avalon transfer, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge core_clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		@(posedge core_clk);
		while (avs_waitrequest !== 1'b0) @(posedge core_clk);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic wait_rsp;
		while (u_cli.got !== 1'b1) @(posedge core_clk);
	endtask
	// Sets a reaction, pulses failure source r, checks the commands
	task automatic fail(input logic [2:0] r, input logic [4:0] e);
		bus(1'b1, 6'h10, {29'h0, r});
		@(posedge core_clk);
		ev[r] <= 1'b1;
		@(posedge core_clk);
		ev[r] <= 1'b0;
		#1;
		chk(cmds === e, "fault commands");
	endtask
	// Drive reports standstill; the fault must follow
	task automatic stopped;
		@(posedge core_clk);
		drive_stopped <= 1'b1;
		@(posedge core_clk);
		drive_stopped <= 1'b0;
		#1;
		chk(cmds === 5'h10, "fault after stop");
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Hang guard, well past the length of the sequence
	initial begin
		repeat (20000) @(posedge core_clk);
		n_mismatch++;
		complete_run;
	end
	initial begin
		repeat (4) @(posedge core_clk);
		srst <= 1'b0;
		for (i = 0; i < 11; i++) begin
			if (rows[i][23:16] != 8'h0) bus(1'b1, rows[i][29:24], {24'h0, rows[i][15:8]});
			bus(1'b0, rows[i][29:24], 32'h0);
			chk(rd === {24'h0, rows[i][7:0]}, "register readback");
		end
		expansion_fitted <= 1'b1;
		bus(1'b1, 6'h00, 32'h2);
		bus(1'b0, 6'h00, 32'h0);
		chk(rd === 32'h2 && can_port === 2'h2 && sysbus_enable === 1'b0 && can_bitrate === 4'h8, "expansion port");
		bus(1'b1, 6'h0c, 32'h5);
		bus(1'b0, 6'h0c, 32'h0);
		chk(rd === 32'hff, "system bus id locked");
		bus(1'b1, 6'h00, 32'h1);
		bus(1'b1, 6'h04, 32'h5);
		bus(1'b1, 6'h00, 32'h2);
		bus(1'b0, 6'h00, 32'h0);
		chk(rd === 32'h1, "port change refused");
		for (i = 1; i < 5; i++) begin
			od_len <= i[2:0];
			stall <= i[3:0];
			u_cli.send(11'h605, 8'h40, 16'h2001, 8'h02);
			wait_rsp;
			chk(u_cli.rsp_id === 11'h585 && u_cli.rsp[39:0] === {16'h1102, 16'h2001, 8'h53 - 8'(4 * i)}, "upload");
		end
		u_cli.send(11'h606, 8'h40, 16'h2001, 8'h02);
		repeat (12) @(posedge core_clk);
		chk(u_cli.got === 1'b0, "foreign node answered");
		od_err <= 1'b1;
		u_cli.send(11'h605, 8'h40, 16'h6041, 8'h00);
		wait_rsp;
		chk(u_cli.rsp === {od_abort_code, 32'h00604180}, "abort frame");
		od_err <= 1'b0;
		abort_opt_wr <= 1'b1;
		abort_opt_data <= 3'h3;
		@(posedge core_clk);
		abort_opt_wr <= 1'b0;
		u_cli.send(11'h605, 8'h40, 16'h6007, 8'h00);
		wait_rsp;
		chk(u_cli.rsp[39:0] === 40'h030060074b, "abort option read");
		bus(1'b0, 6'h10, 32'h0);
		chk(rd === 32'h3, "shared reaction");
		remote_ctrl <= 1'b1;
		fail(3'h0, 5'h00);
		fail(3'h1, 5'h10);
		fail(3'h2, 5'h09);
		fail(3'h3, 5'h05);
		fail(3'h4, 5'h02);
		stopped;
		fail(3'h5, 5'h04);
		stopped;
		remote_ctrl <= 1'b0;
		fail(3'h2, 5'h00);
		complete_run;
	end
endmodule // canopen_sdo_server_tb
`default_nettype wire
